/* File: rtl/sadc_params.svh */
// Timing constants and widths for the converter control and read port
`ifndef SADC_PARAMS_SVH
`define SADC_PARAMS_SVH
`define SADC_CLK_NS 100
`define SADC_CLK_PERIOD_NS 10
`define SADC_DATA_W 16
`define SADC_CONV_NS 8000
`define SADC_CONV_CYC (`SADC_CONV_NS / `SADC_CLK_PERIOD_NS)
`define SADC_BUSY_FALL_NS 85
`define SADC_BUSY_FALL_CYC ((`SADC_BUSY_FALL_NS / `SADC_CLK_PERIOD_NS) > 0 ? (`SADC_BUSY_FALL_NS / `SADC_CLK_PERIOD_NS) : 1)
`define SADC_EOC_BUSY_NS 220
`define SADC_EOC_BUSY_CYC ((`SADC_EOC_BUSY_NS + `SADC_CLK_PERIOD_NS - 1) / `SADC_CLK_PERIOD_NS)
`define SADC_VALID_BUSY_NS 50
`define SADC_VALID_BUSY_CYC ((`SADC_VALID_BUSY_NS + `SADC_CLK_PERIOD_NS - 1) / `SADC_CLK_PERIOD_NS)
`define SADC_PREV_HOLD_NS 7400
`define SADC_PREV_HOLD_CYC (`SADC_PREV_HOLD_NS / `SADC_CLK_PERIOD_NS)
`define SADC_FIFO_DEPTH 8
`endif

/* File: rtl/sadc_pkg.sv */
// Types shared by the converter control and read port
package sadc_pkg;
  typedef enum logic [3:0] {
    SADC_IDLE = 4'b0001,
    SADC_CONV = 4'b0010,
    SADC_EOC = 4'b0100,
    SADC_VALID = 4'b1000
  } sadc_state_t;
endpackage

/* File: rtl/sadc_fifo.sv */
// Small flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ns
module sadc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clkEn,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  logic doWr;
  logic doRd;

  assign inReady = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign doWr = clkEn && inValid && inReady;
  assign doRd = clkEn && outValid && outReady;
  assign outData = mem[rdPtr];

  always_ff @(posedge clk_sys)
  begin
    if (doWr)
    begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end
    else
    begin
      if (doWr)
        wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      if (doRd)
        rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      if (doWr && !doRd)
        count <= count + 1'b1;
      else if (doRd && !doWr)
        count <= count - 1'b1;
    end
  end
endmodule // sadc_fifo

/* File: rtl/sadc_port.sv */
// Converter control and parallel read port: strobes, busy, result bus
// Summary of operation
// - Chip select high: bus floats, nothing happens.
// - Select falls, convert low: start, bus floats.
// - Convert falls, select low: start, bus floats.
// - Busy rising with read selected shows result.
// - Select falls, convert high, idle: show result.
// - Select falls during conversion: show previous result.
// - Result is 16-bit two's complement word.
// - Result valid, busy low, within 8 us.
// - Busy falls within 85 ns of start.
// - Busy rises 220 ns after conversion end.
// - Busy rises 50 ns after data valid; here the word updates 22 cycles (220 ns) before busy rises.
// - Previous result readable until 7.4 us.
// - Select and convert OR'ed; last falling starts.
// - Convert commands ignored while busy low.
// - Protection status high: data invalid, no drive high.
`timescale 1ns/1ns
`include "sadc_params.svh"
module sadc_port
  import sadc_pkg::*;
#(
  parameter int DATA_W = `SADC_DATA_W,
  parameter int CONV_CYC = `SADC_CONV_CYC,
  parameter int FIFO_DEPTH = `SADC_FIFO_DEPTH
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clkEn,
  // Control pins, active low strobes from the controller
  input wire logic chipSel_n,
  input wire logic readConv_n,
  output logic busy_n,
  // Result bus pins
  output logic [DATA_W-1:0] resultOut,
  output logic resultOe,
  // Protection status
  input wire logic protFault,
  output logic protStatus,
  // Samples from the internal converter core
  input wire logic sampleValid,
  output logic sampleReady,
  input wire logic [DATA_W-1:0] sampleData
);
  localparam int CW = $clog2(CONV_CYC + 1);
  localparam int BFC = `SADC_BUSY_FALL_CYC;
  localparam int EBC = `SADC_EOC_BUSY_CYC;
  localparam int VBC = `SADC_VALID_BUSY_CYC;
  localparam int PHC = `SADC_PREV_HOLD_CYC;

  sadc_state_t state;
  sadc_state_t next_state;
  logic [1:0] csSync;
  logic [1:0] rcSync;
  logic [1:0] faultSync;
  logic csPrev;
  logic rcPrev;
  logic [CW-1:0] timer;
  logic [DATA_W-1:0] lastResult;
  logic [DATA_W-1:0] newResult;
  logic startReq;
  logic readEdge;
  logic csLow;
  logic rcLow;
  logic csFall;
  logic rcFall;
  logic fifoValid;
  logic fifoTake;
  logic [DATA_W-1:0] fifoData;
  logic busyReg;
  logic readOpen;

  // Pins arrive from another domain
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      csSync <= 2'h3;
      rcSync <= 2'h3;
      faultSync <= 2'h0;
    end
    else if (clkEn)
    begin
      csSync <= {csSync[0], chipSel_n};
      rcSync <= {rcSync[0], readConv_n};
      faultSync <= {faultSync[0], protFault};
    end
  end

  assign csLow = !csSync[1];
  assign rcLow = !rcSync[1];

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      csPrev <= 1'b1;
      rcPrev <= 1'b1;
    end
    else if (clkEn)
    begin
      csPrev <= csSync[1];
      rcPrev <= rcSync[1];
    end
  end

  assign csFall = csPrev && csLow;
  assign rcFall = rcPrev && rcLow;
  // The OR of the two strobes falling is the only start event
  assign startReq = (csFall && rcLow) || (rcFall && csLow);
  assign readEdge = csFall && !rcLow;

  // Core samples are buffered so a late reader stalls the converter only once all FIFO_DEPTH entries are full
  sadc_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .inValid(sampleValid),
    .inReady(sampleReady),
    .inData(sampleData),
    .outValid(fifoValid),
    .outReady(fifoTake),
    .outData(fifoData)
  );

  // Take one sample per conversion, at the start command
  assign fifoTake = (state == SADC_IDLE) && startReq && !faultSync[1];

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      state <= SADC_IDLE;
    else if (clkEn)
      state <= next_state;
  end

  always_comb
  begin
    next_state = state;
    case (state)
      SADC_IDLE:
        if (startReq && !faultSync[1])
          next_state = SADC_CONV;
      // New commands have no effect until the state returns to SADC_IDLE
      SADC_CONV:
        if (timer == CW'(CONV_CYC - EBC - 1))
          next_state = SADC_VALID;
      SADC_VALID:
        if (timer == CW'(CONV_CYC - EBC + VBC - 1))
          next_state = SADC_EOC;
      SADC_EOC:
        if (timer == CW'(CONV_CYC - 1))
          next_state = SADC_IDLE;
      default:
        next_state = SADC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      timer <= '0;
    else if (clkEn)
    begin
      if (state == SADC_IDLE)
        timer <= '0;
      else
        timer <= timer + 1'b1;
    end
  end

  // Busy low one cycle after start, well inside the fall limit
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      busyReg <= 1'b1;
    else if (clkEn)
      busyReg <= (next_state == SADC_IDLE);
  end

  assign busy_n = busyReg;

  // Captured at start; a word with no sample left repeats the last one
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      newResult <= '0;
    else if (clkEn && fifoTake)
      newResult <= fifoValid ? fifoData : lastResult;
  end

  // Previous word stays readable until the update point, which lies past the hold time at the default length
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      lastResult <= '0;
    else if (clkEn && state == SADC_CONV && next_state == SADC_VALID)
      lastResult <= newResult;
  end

  // Bus opens on a read edge or at the end of a conversion while read is selected
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      readOpen <= 1'b0;
    else if (clkEn)
    begin
      if (!csLow || faultSync[1])
        readOpen <= 1'b0;
      else if (startReq)
        readOpen <= 1'b0;
      else if (readEdge)
        readOpen <= 1'b1;
      else if (state == SADC_EOC && next_state == SADC_IDLE && !rcLow)
        readOpen <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      resultOut <= '0;
      resultOe <= 1'b0;
    end
    else if (clkEn)
    begin
      // A start closes the bus at once, even after a read edge one cycle earlier
      resultOe <= readOpen && !startReq && !faultSync[1];
      // Drive low while in fault so the pins never source current
      resultOut <= faultSync[1] ? '0 : lastResult;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      protStatus <= 1'b0;
    else if (clkEn)
      protStatus <= faultSync[1];
  end

  // Unused constant kept for the busy fall timing rule
  localparam int UNUSED_BFC = BFC;
endmodule // sadc_port

/* File: test/sadc_port_sva.sv */
// Checker for the converter port pins
`timescale 1ns/1ns
module sadc_port_sva #(
  parameter int DATA_W = 16,
  parameter int CONV_CYC = 800
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Pins
  input wire logic chipSel_n,
  input wire logic readConv_n,
  input wire logic busy_n,
  input wire logic [DATA_W-1:0] resultOut,
  input wire logic resultOe,
  input wire logic protFault,
  input wire logic protStatus
);
  localparam int BUSY_MAX = CONV_CYC + 8;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  bus_off_a: assert property (chipSel_n [*5] |-> !resultOe) else $error("bus driven while deselected");
  read_on_a: assert property ($fell(chipSel_n) && readConv_n && !protStatus ##1 (!chipSel_n && readConv_n) [*5]
    |-> resultOe) else $error("read did not enable bus");
  start_busy_a: assert property ($fell(chipSel_n || readConv_n) && busy_n && !protStatus && !protFault
    |-> ##[1:8] !busy_n) else $error("busy late after start");
  busy_len_a: assert property ($fell(busy_n) |-> ##[1:BUSY_MAX] busy_n) else $error("busy low too long");
  word_early_a: assert property ($rose(busy_n) |-> $past(resultOut, 5) == resultOut)
    else $error("word not settled before busy");
  prev_hold_a: assert property ($fell(busy_n) |=> $stable(resultOut) [*8]) else $error("old word lost");
  start_off_a: assert property ($fell(busy_n) |-> !resultOe) else $error("bus driven at start");
  fault_quiet_a: assert property (protStatus && $past(protStatus) |-> !resultOe && resultOut == '0)
    else $error("bus active during fault");
  cover property ($rose(busy_n));
  cover property ($rose(resultOe) && !busy_n);
  cover property ($rose(protStatus));
endmodule // sadc_port_sva
bind sadc_port sadc_port_sva #(.DATA_W(DATA_W), .CONV_CYC(CONV_CYC)) i_sadc_port_sva (.clk_sys(clk_sys),
  .rst_n(rst_n), .chipSel_n(chipSel_n), .readConv_n(readConv_n), .busy_n(busy_n), .resultOut(resultOut),
  .resultOe(resultOe), .protFault(protFault), .protStatus(protStatus));

/* File: test/sadc_host.sv */
// Controller model driving the select and read/convert strobes
`timescale 1ns/1ns
module sadc_host (
  // Clock
  input wire logic clk_sys,
  // Strobes and result
  output logic chipSel_n,
  output logic readConv_n,
  input wire logic busy_n,
  input wire logic [15:0] resultOut
);
  initial
  begin
    chipSel_n = 1'b1;
    readConv_n = 1'b1;
  end
  // Mode 1 lets convert fall last; a mid-conversion read follows each start
  task automatic convert(input bit md, output bit ok, output logic [15:0] mid);
    int n;
    begin
      n = 0;
      mid = '0;
      @(posedge clk_sys);
      #1;
      if (md)
        chipSel_n = 1'b0;
      else
        readConv_n = 1'b0;
      @(posedge clk_sys);
      #1 chipSel_n = 1'b0;
      readConv_n = 1'b0;
      while (busy_n && n < 20)
      begin
        @(posedge clk_sys);
        #1 n++;
      end
      chipSel_n = 1'b1;
      readConv_n = 1'b1;
      ok = !busy_n;
      if (ok)
      begin
        repeat (2) @(posedge clk_sys);
        #1 chipSel_n = 1'b0;
        repeat (5) @(posedge clk_sys);
        #1 mid = resultOut;
        chipSel_n = 1'b1;
        n = 0;
        while (!busy_n && n < 200)
        begin
          @(posedge clk_sys);
          #1 n++;
        end
        ok = busy_n;
        repeat (4) @(posedge clk_sys);
      end
    end
  endtask
  task automatic read(output logic [15:0] d);
    begin
      @(posedge clk_sys);
      #1 chipSel_n = 1'b0;
      repeat (6) @(posedge clk_sys);
      #1 d = resultOut;
      chipSel_n = 1'b1;
    end
  endtask
endmodule // sadc_host

/* File: test/testbench.sv */
// Self-checking bench for the converter port
`timescale 1ns/1ns
module testbench;
  logic clk_sys, rst_n, clkEn, protFault, sampleValid, sampleReady, protStatus, busy_n, resultOe;
  logic chipSel_n, readConv_n;
  logic [15:0] sampleData, resultOut, d, m;
  int miscompares = 0, total_checks = 0, q[$], last = 0;
  bit ok;
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Short conversion keeps the run brief
  sadc_port #(.CONV_CYC(40)) i_sadc_port (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn),
    .chipSel_n(chipSel_n), .readConv_n(readConv_n), .busy_n(busy_n), .resultOut(resultOut),
    .resultOe(resultOe), .protFault(protFault), .protStatus(protStatus), .sampleValid(sampleValid),
    .sampleReady(sampleReady), .sampleData(sampleData));
  sadc_host i_sadc_host (.clk_sys(clk_sys), .chipSel_n(chipSel_n), .readConv_n(readConv_n),
    .busy_n(busy_n), .resultOut(resultOut));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic push(input logic [15:0] v);
    @(posedge clk_sys);
    #1 sampleValid = 1'b1;
    sampleData = v;
    chk(sampleReady, 1);
    @(posedge clk_sys);
    q.push_back(v);
    #1 sampleValid = 1'b0;
  endtask
  // Empty queue repeats the last word
  task automatic conv(input bit md);
    i_sadc_host.convert(md, ok, m);
    chk(ok, 1);
    if (!ok)
      tally_and_finish();
    chk(m, last);
    if (q.size() > 0)
      last = q.pop_front();
    i_sadc_host.read(d);
    chk(d, last);
  endtask
  initial
  begin
    rst_n = 1'b0;
    clkEn = 1'b1;
    protFault = 1'b0;
    sampleValid = 1'b0;
    sampleData = '0;
    void'($urandom(99));
    repeat (4) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    chk(busy_n, 1);
    chk(resultOe, 0);
    repeat (3) @(posedge clk_sys);
    for (int i = 0; i < 4; i++)
    begin
      push(16'($urandom));
      conv(i[0]);
    end
    $display("test conversions done");
    repeat (8) push(16'($urandom));
    chk(sampleReady, 0);
    repeat (9) conv(1'b0);
    $display("test full queue done");
    protFault = 1'b1;
    repeat (6) @(posedge clk_sys);
    #1 chk(protStatus, 1);
    i_sadc_host.convert(1'b0, ok, m);
    chk(ok, 0);
    chk(resultOe, 0);
    protFault = 1'b0;
    repeat (6) @(posedge clk_sys);
    #1 chk(protStatus, 0);
    $display("test fault done");
    tally_and_finish();
  end
endmodule // testbench
